// ---- shared/pcs_pkg.sv ----
//==============================================================
// Program counter and return stack shared definitions.
package pcs_pkg;

	//==========================================================
	// Widths.
	localparam int PC_W    = 13;
	localparam int LATCH_W = 8;
	localparam int HIGH_W  = 5;
	localparam int FIELD_W = 11;
	localparam int DEPTH   = 8;
	localparam int PTR_W   = 3;

	//==========================================================
	// Field positions.
	localparam int PAGE_BIT = 3;
	localparam int LOW_MSB  = 7;

	//==========================================================
	// Values after reset and fixed addresses.
	localparam logic [PC_W-1:0]    PC_RESET    = 13'h0000;
	localparam logic [PC_W-1:0]    INTR_VECTOR = 13'h0004;
	localparam logic [LATCH_W-1:0] LATCH_RESET = 8'h00;
	localparam logic [PTR_W-1:0]   PTR_RESET   = 3'h0;
	localparam logic [PTR_W-1:0]   PTR_STEP    = 3'h1;
	localparam logic [PC_W-1:0]    PC_STEP     = 13'h0001;
	localparam logic [PC_W-1:0]    MEM_RESET   = 13'h0000;

	//==========================================================
	// State of the counter core.
	typedef struct packed {
		logic [PC_W-1:0]    pc;
		logic [LATCH_W-1:0] latch;
	} pcs_core_t;

	//==========================================================
	// State of the return stack.
	typedef struct packed {
		logic [DEPTH-1:0][PC_W-1:0] mem;
		logic [PTR_W-1:0]           ptr;
	} pcs_stack_t;

endpackage : pcs_pkg

// ---- shared/pcs_stack_if.sv ----
`timescale 1ns/1ns
//==============================================================
// Push and pop requests between the counter and the stack.
interface pcs_stack_if;
	import pcs_pkg::*;

	logic            push;
	logic            pop;
	logic [PC_W-1:0] push_data;
	logic [PC_W-1:0] top_data;

	modport ctrl
	(
		output push,
		output pop,
		output push_data,
		input  top_data
	);

	modport store
	(
		input  push,
		input  pop,
		input  push_data,
		output top_data
	);

endinterface : pcs_stack_if

// ---- core/pcs_stack.sv ----
`timescale 1ns/1ns
//==============================================================
// Eight-entry circular return-address stack.
module pcs_stack
(
	input  wire logic mclk_i,
	input  wire logic rst_n_i,
	pcs_stack_if.store stk
);
	import pcs_pkg::*;

	pcs_stack_t st;
	pcs_stack_t next_st;

	//==========================================================
	// Top of stack is the entry just below the pointer.
	assign stk.top_data = st.mem[PTR_W'(st.ptr - PTR_STEP)];

	//==========================================================
	// Push writes at the pointer and advances it; the pointer
	// wraps, so the ninth push lands on the first entry.
	always_comb
	begin
		next_st = st;
		if (stk.push)
		begin
			next_st.mem[st.ptr] = stk.push_data;
			next_st.ptr         = PTR_W'(st.ptr + PTR_STEP);
		end
		else if (stk.pop)
		begin
			next_st.ptr = PTR_W'(st.ptr - PTR_STEP);
		end
	end

	// The stack sits outside both memory spaces; no software port reads it.
	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			st.mem <= {DEPTH{MEM_RESET}};
			st.ptr <= PTR_RESET;
		end
		else
		begin
			st <= next_st;
		end
	end

	//==========================================================
	// Checks.
	a_push_stores: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		stk.push |=> st.mem[$past(st.ptr)] == $past(stk.push_data))
		else $error("Pushed address not stored at the pointer.");

	a_ptr_wraps: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		(stk.push && st.ptr == 3'h7) |=> st.ptr == 3'h0)
		else $error("Stack pointer did not wrap after the eighth entry.");

	c_stack_wrap: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
		stk.push && st.ptr == 3'h7);

endmodule : pcs_stack

// ---- core/pcs_top.sv ----
`timescale 1ns/1ns
//==============================================================
// Program counter, return stack and page selection.

// How it works
// - A 13-bit counter gives the next fetch address.
// - The low counter byte is readable and writable by software.
// - Upper counter bits are never written directly; software loads them only through the holding latch.
// - Eight 13-bit stack entries, hidden pointer, outside both memory spaces.
// - Calls and taken interrupts push the counter.
// - Plain return, return with literal and interrupt return pop the stack.
// - Push and pop leave the holding latch untouched.
// - Circular stack, no overflow flag; ninth push overwrites the first.
// - Call and jump carry an 11-bit target within a 2K page.
// - Counter bit 11 for call and jump comes from latch bit 3.
// - Full 13-bit counter saved and restored, no page fix needed.
module pcs_top
(
	input  wire logic                            mclk_i,
	input  wire logic                            rst_n_i,
	input  wire logic                            fetch_i,
	input  wire logic                            goto_i,
	input  wire logic                            call_i,
	input  wire logic [pcs_pkg::FIELD_W-1:0]     target_i,
	input  wire logic                            ret_plain_i,
	input  wire logic                            return_with_literal_i,
	input  wire logic                            return_from_interrupt_i,
	input  wire logic                            irq_i,
	input  wire logic                            pc_low_byte_wr_i,
	input  wire logic [pcs_pkg::LOW_MSB:0]       pc_low_byte_wdata_i,
	input  wire logic                            latch_wr_i,
	input  wire logic [pcs_pkg::LATCH_W-1:0]     latch_wdata_i,
	output      logic [pcs_pkg::PC_W-1:0]        pc_o,
	output      logic [pcs_pkg::LOW_MSB:0]       pc_low_byte_o,
	output      logic [pcs_pkg::LATCH_W-1:0]     pc_high_holding_latch_o
);
	import pcs_pkg::*;

	//==========================================================
	// State and stack link.
	pcs_core_t   st;
	pcs_core_t   next_st;
	logic        any_ret;
	logic [PC_W-1:0] branch_target;
	logic [PC_W-1:0] low_write_target;

	pcs_stack_if stk_bus ();

	//==========================================================
	// Return stack.
	pcs_stack u_stack
	(
		.mclk_i  (mclk_i),
		.rst_n_i (rst_n_i),
		.stk     (stk_bus.store)
	);

	//==========================================================
	// Target forming.
	// All three return kinds pop the same way; the literal for
	// the second kind is handled by the data path elsewhere.
	assign any_ret = ret_plain_i | return_with_literal_i | return_from_interrupt_i;

	// Page bit comes from the latch as it stands; software must
	// have set it beforehand or the branch lands in the wrong page.
	assign branch_target = {1'b0, st.latch[PAGE_BIT], target_i};

	// A low-byte write also loads the upper bits from the latch.
	assign low_write_target = {st.latch[HIGH_W-1:0], pc_low_byte_wdata_i};

	//==========================================================
	// Next-state selection. Priority: interrupt, call, jump,
	// return, low-byte write, plain fetch increment.
	always_comb
	begin
		next_st           = st;
		stk_bus.push      = 1'b0;
		stk_bus.pop       = 1'b0;
		stk_bus.push_data = st.pc;
		if (irq_i)
		begin
			stk_bus.push = 1'b1;
			next_st.pc   = INTR_VECTOR;
		end
		else if (call_i)
		begin
			stk_bus.push = 1'b1;
			next_st.pc   = branch_target;
		end
		else if (goto_i)
		begin
			next_st.pc = branch_target;
		end
		else if (any_ret)
		begin
			stk_bus.pop = 1'b1;
			next_st.pc  = stk_bus.top_data;
		end
		else if (pc_low_byte_wr_i)
		begin
			next_st.pc = low_write_target;
		end
		else if (fetch_i)
		begin
			next_st.pc = PC_W'(st.pc + PC_STEP);
		end
		// The latch is written by software only; stack traffic
		// never touches it.
		if (latch_wr_i)
		begin
			next_st.latch = latch_wdata_i;
		end
	end

	//==========================================================
	// State register.
	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			st.pc    <= PC_RESET;
			st.latch <= LATCH_RESET;
		end
		else
		begin
			st <= next_st;
		end
	end

	//==========================================================
	// Outputs, all straight from the state flops.
	assign pc_o                    = st.pc;
	assign pc_low_byte_o           = st.pc[LOW_MSB:0];
	assign pc_high_holding_latch_o = st.latch;

	//==========================================================
	// Helper terms for the checks.
	logic fetch_only;
	logic call_only;
	logic ret_only;
	logic low_wr_only;
	logic goto_only;
	logic no_pc_req;
	logic low_rolls;
	logic upper_quiet;

	assign fetch_only  = fetch_i & ~irq_i & ~call_i & ~goto_i & ~any_ret
		& ~pc_low_byte_wr_i;
	assign call_only   = call_i & ~irq_i;
	assign ret_only    = any_ret & ~irq_i & ~call_i & ~goto_i;
	assign low_wr_only = pc_low_byte_wr_i & ~irq_i & ~call_i & ~goto_i
		& ~any_ret;
	assign goto_only   = goto_i & ~irq_i & ~call_i;
	assign no_pc_req   = ~irq_i & ~call_i & ~goto_i & ~any_ret & ~pc_low_byte_wr_i
		& ~fetch_i;
	assign low_rolls   = fetch_only & (pc_o[LOW_MSB:0] == 8'hFF);
	assign upper_quiet = ~irq_i & ~call_i & ~goto_i & ~any_ret & ~pc_low_byte_wr_i
		& ~low_rolls;

	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!rst_n_i);

	//==========================================================
	// Checks.
	a_fetch_increment: assert property (
		fetch_only |=> pc_o == PC_W'($past(pc_o) + PC_STEP))
		else $error("Counter did not advance by one on a fetch.");

	a_counter_wraps: assert property (
		(fetch_only && pc_o == 13'h1FFF) |=> pc_o == 13'h0000)
		else $error("Counter did not wrap at 13 bits.");

	a_high_held: assert property (
		(fetch_only && pc_o[7:0] != 8'hFF) |=> $stable(pc_o[12:8]))
		else $error("Upper counter bits moved without a carry or load.");

	a_low_write_load: assert property (
		low_wr_only |=> pc_o == {$past(st.latch[4:0]), $past(pc_low_byte_wdata_i)})
		else $error("Low-byte write did not load the latch bits.");

	a_low_byte_view: assert property (
		low_wr_only |=> pc_low_byte_o == $past(pc_low_byte_wdata_i))
		else $error("Low byte does not read back the written value.");

	a_call_page: assert property (
		call_only |=> pc_o == {$past(st.latch[3]), $past(target_i)})
		else $error("Call target not formed from latch bit and field.");

	a_irq_vector: assert property (
		irq_i |=> pc_o == INTR_VECTOR)
		else $error("Interrupt did not branch to the vector.");

	a_return_restores: assert property (
		(call_only ##1 ret_only) |=> pc_o == $past(pc_o, 2))
		else $error("Return did not restore the saved counter.");

	a_latch_kept: assert property (
		((irq_i || call_i || any_ret) && !latch_wr_i) |=> $stable(pc_high_holding_latch_o))
		else $error("Holding latch changed on stack traffic.");

	a_page_jump: assert property (
		(goto_i && !irq_i && !call_i) |=> pc_o[10:0] == $past(target_i))
		else $error("Jump did not take the 11-bit field.");

	//==========================================================
	// Checks on stack traffic and paging. These watch the
	// counter through the stack rather than copying the
	// next-state expressions, so a wrong pointer or a wrong
	// page bit shows up as a wrong landing address.

	// A return from interrupt lands where the interrupt struck,
	// whatever page the latch names by then.
	a_irq_return: assert property (
		(irq_i ##1 (return_from_interrupt_i && ret_only)) |=> pc_o == $past(pc_o, 2))
		else $error("Interrupt return did not resume at the saved address.");

	// The literal return pops exactly like the plain one; the
	// literal itself travels on the data side.
	a_lit_return: assert property (
		(call_only ##1 (return_with_literal_i && ret_only)) |=> pc_o == $past(pc_o, 2))
		else $error("Literal return did not restore the saved counter.");

	// A jump takes its page bit from the latch exactly as a call
	// does; bit 12 stays clear because only one page bit exists.
	a_goto_page: assert property (
		goto_only |=> pc_o == {1'b0, $past(st.latch[PAGE_BIT]), $past(target_i)})
		else $error("Jump target not formed from latch bit and field.");

	// A jump pushes nothing, so a return right after it pops the
	// entry that was on top before the jump.
	a_goto_no_push: assert property (
		(goto_only ##1 ret_only) |=> pc_o == $past(stk_bus.top_data, 2))
		else $error("Jump disturbed the return stack.");

	// Every return kind loads the top entry into the counter.
	// The entry is taken before the pointer moves.
	a_ret_pops: assert property (
		ret_only |=> pc_o == $past(stk_bus.top_data))
		else $error("Return did not load the top stack entry.");

	// Two nested calls unwind in reverse order; a pointer that
	// moved the wrong way would return to the inner site twice.
	a_nested_calls: assert property (
		(call_only ##1 call_only ##1 ret_only ##1 ret_only) |=> pc_o == $past(pc_o, 4))
		else $error("Nested calls did not unwind in order.");

	// A latch write lands whole, with no stack or branch side
	// effects on its value.
	a_latch_load: assert property (
		latch_wr_i |=> pc_high_holding_latch_o == $past(latch_wdata_i))
		else $error("Holding latch did not take the written value.");

	// Without a write the latch holds, whatever the counter and
	// the stack are doing in the same cycle.
	a_latch_quiet: assert property (
		!latch_wr_i |=> $stable(pc_high_holding_latch_o))
		else $error("Holding latch changed without a write.");

	// With no request at all the counter must stand still; a
	// stray increment would skip an instruction.
	a_idle_hold: assert property (
		no_pc_req |=> $stable(pc_o))
		else $error("Counter moved with no request.");

	// The upper bits move only through a branch, a return, a
	// low-byte load or a carry out of the low byte.
	a_upper_quiet: assert property (
		upper_quiet |=> $stable(pc_o[12:8]))
		else $error("Upper counter bits changed without a load or carry.");

	// A carry out of the low byte bumps the upper bits by one.
	// The top count is left to the wrap check above.
	a_carry_up: assert property (
		(low_rolls && pc_o[12:8] != 5'h1F) |=> pc_o[12:8] == 5'($past(pc_o[12:8]) + 5'h01))
		else $error("Carry out of the low byte was lost.");

	// The low byte rolls to zero on that same carry.
	// Software reading it then sees the start of the block.
	a_low_rolls: assert property (
		low_rolls |=> pc_low_byte_o == 8'h00)
		else $error("Low byte did not roll over to zero.");

	// The software view of the low byte follows a taken
	// interrupt to the vector.
	a_vector_low: assert property (
		irq_i |=> pc_low_byte_o == INTR_VECTOR[LOW_MSB:0])
		else $error("Low byte does not show the interrupt vector.");

	// A call puts the low part of its field straight into the
	// software-visible low byte.
	a_call_low: assert property (
		call_only |=> pc_low_byte_o == $past(target_i[LOW_MSB:0]))
		else $error("Low byte does not show the call target.");

	// A jump does the same with its own field.
	// The page bit plays no part in the low byte.
	a_goto_low: assert property (
		goto_only |=> pc_low_byte_o == $past(target_i[LOW_MSB:0]))
		else $error("Low byte does not show the jump target.");

	//==========================================================
	// Main scenarios.
	c_call_return: cover property (call_only ##1 ret_only);
	c_irq_taken:   cover property (irq_i);
	c_low_write:   cover property (low_wr_only);
	c_fetch_wrap:  cover property (fetch_only && pc_o == 13'h1FFF);

endmodule : pcs_top

// ---- test/pcs_decode_model.sv ----
`timescale 1ns/1ns
//==============================================================
// Decode-side partner: turns a request mask into the block strobes.
module pcs_decode_model
(
	input  wire logic [7:0] req_i,
	output      logic       fetch_o,
	output      logic       goto_o,
	output      logic       call_o,
	output      logic       ret_plain_o,
	output      logic       ret_lit_o,
	output      logic       ret_int_o,
	output      logic       irq_o,
	output      logic       low_wr_o
);
	// Strobes are one-cycle levels; several may stand together on purpose.
	assign fetch_o     = req_i[0];
	assign goto_o      = req_i[1];
	assign call_o      = req_i[2];
	assign ret_plain_o = req_i[3];
	assign ret_lit_o   = req_i[4];
	assign ret_int_o   = req_i[5];
	assign irq_o       = req_i[6];
	assign low_wr_o    = req_i[7];
endmodule : pcs_decode_model

// ---- test/pcs_top_tb.sv ----
`timescale 1ns/1ns
//==============================================================
// Self-checking bench for the counter, return stack and paging.
module pcs_top_tb;
	import pcs_pkg::*;

	logic                       mclk_i  = 1'b0;
	logic                       rst_n_i = 1'b0;
	logic [7:0]                 req     = 8'h00;
	logic [FIELD_W-1:0]         tgt     = 11'h000;
	logic [7:0]                 wd      = 8'h00;
	logic                       lw      = 1'b0;
	logic [LATCH_W-1:0]         lwd     = 8'h00;
	logic                       fe, go, ca, rp, rl, ri, iq, lo;
	logic [PC_W-1:0]            pc_o;
	logic [7:0]                 low_o;
	logic [LATCH_W-1:0]         lat_o;
	logic [PC_W-1:0]            pc      = PC_RESET;
	logic [DEPTH-1:0][PC_W-1:0] stk     = '0;
	logic [PTR_W-1:0]           sp      = PTR_RESET;
	logic [LATCH_W-1:0]         lat     = LATCH_RESET;
	logic [PC_W+LATCH_W-1:0]    q [$];
	logic [PC_W+LATCH_W-1:0]    e;
	int                         err_count   = 0;
	int                         check_count = 0;
	int                         seed        = 32'h1F03437D;

	// Free-running core clock, 8 ns period.
	always #4 mclk_i = ~mclk_i;

	pcs_decode_model dm_u (.req_i(req), .fetch_o(fe), .goto_o(go), .call_o(ca),
		.ret_plain_o(rp), .ret_lit_o(rl), .ret_int_o(ri), .irq_o(iq), .low_wr_o(lo));

	pcs_top dut_u (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .fetch_i(fe), .goto_i(go),
		.call_i(ca), .target_i(tgt), .ret_plain_i(rp), .return_with_literal_i(rl),
		.return_from_interrupt_i(ri), .irq_i(iq), .pc_low_byte_wr_i(lo),
		.pc_low_byte_wdata_i(wd), .latch_wr_i(lw), .latch_wdata_i(lwd), .pc_o(pc_o),
		.pc_low_byte_o(low_o), .pc_high_holding_latch_o(lat_o));

	task chk_pc(input logic [PC_W-1:0] x, input logic [PC_W-1:0] g);
		check_count++;
		if (g !== x)
		begin
			err_count++;
			$display("unexpected at %0t: counter %h, wanted %h", $time, g, x);
		end
	endtask : chk_pc

	task chk_byte(input logic [7:0] x, input logic [7:0] g);
		check_count++;
		if (g !== x)
		begin
			err_count++;
			$display("unexpected at %0t: byte %h, wanted %h", $time, g, x);
		end
	endtask : chk_byte

	task end_sim;
		$display("checks %0d, mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : end_sim

	// Drives one cycle of requests and notes the expected outcome.
	task step(input logic [7:0] r, input logic [FIELD_W-1:0] t, input logic [7:0] w,
		input logic l, input logic [7:0] ld);
		@(negedge mclk_i);
		req = r;
		tgt = t;
		wd  = w;
		lw  = l;
		lwd = ld;
		if (r[6] | r[2])
		begin
			stk[sp] = pc;
			sp      = sp + PTR_STEP;
		end
		if (r[6])
			pc = INTR_VECTOR;
		else if (r[2] | r[1])
			pc = {1'b0, lat[PAGE_BIT], t};
		else if (|r[5:3])
		begin
			sp = sp - PTR_STEP;
			pc = stk[sp];
		end
		else if (r[7])
			pc = {lat[HIGH_W-1:0], w};
		else if (r[0])
			pc = pc + PC_STEP;
		if (l)
			lat = ld;
		q.push_back({pc, lat});
	endtask : step

	// Watches the outputs after each rising edge and takes the oldest note.
	always @(posedge mclk_i)
	begin
		#1;
		if (q.size() > 0)
		begin
			e = q.pop_front();
			chk_pc(e[20:8], pc_o);
			chk_byte(e[15:8], low_o);
			chk_byte(e[7:0], lat_o);
		end
	end

	// Main sequence.
	initial
	begin
		repeat (6) @(negedge mclk_i);
		rst_n_i = 1'b1;
		chk_pc(PC_RESET, pc_o);
		step(8'h00, 11'h000, 8'h00, 1'b1, 8'h08);
		step(8'h01, 11'h000, 8'h00, 1'b0, 8'h00);
		step(8'h04, 11'h123, 8'h00, 1'b0, 8'h00);
		step(8'h08, 11'h000, 8'h00, 1'b0, 8'h00);
		step(8'h00, 11'h000, 8'h00, 1'b1, 8'hFF);
		step(8'h80, 11'h000, 8'hFF, 1'b0, 8'h00);
		step(8'h01, 11'h000, 8'h00, 1'b0, 8'h00);
		for (int i = 0; i < 10; i++)
			step(8'h04, 11'($random(seed)), 8'h00, 1'b1, 8'($random(seed)));
		for (int i = 0; i < 10; i++)
			step(8'h08 << (i % 3), 11'h000, 8'h00, 1'b1, 8'($random(seed)));
		step(8'h41, 11'h000, 8'h00, 1'b0, 8'h00);
		step(8'h20, 11'h000, 8'h00, 1'b0, 8'h00);
		repeat (400)
			step(8'($random(seed)), 11'($random(seed)), 8'($random(seed)),
				1'($random(seed)), 8'($random(seed)));
		step(8'h00, 11'h000, 8'h00, 1'b0, 8'h00);
		for (int k = 0; k < 5 && q.size() > 0; k++)
			@(negedge mclk_i);
		// Mid-run reset: counter, latch and every stack entry clear.
		rst_n_i = 1'b0;
		pc      = PC_RESET;
		stk     = {DEPTH{MEM_RESET}};
		sp      = PTR_RESET;
		lat     = LATCH_RESET;
		repeat (2) @(negedge mclk_i);
		rst_n_i = 1'b1;
		chk_pc(PC_RESET, pc_o);
		chk_byte(LATCH_RESET, lat_o);
		step(8'h01, 11'h000, 8'h00, 1'b0, 8'h00);
		step(8'h01, 11'h000, 8'h00, 1'b0, 8'h00);
		step(8'h08, 11'h000, 8'h00, 1'b0, 8'h00);
		step(8'h00, 11'h000, 8'h00, 1'b0, 8'h00);
		for (int k = 0; k < 5 && q.size() > 0; k++)
			@(negedge mclk_i);
		if (q.size() > 0)
		begin
			err_count++;
			$display("unexpected at %0t: results still pending", $time);
		end
		end_sim();
	end
endmodule : pcs_top_tb
